// ### hdl/dcf_framer.sv
// Daisy chain data framer top
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"
module dcf_framer
   import dcf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]      rdata,
   // Measurement and data
   input  wire logic        meas_active,
   input  wire logic        meas_done,
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_first,
   input  wire logic [15:0] conv_second,
   input  wire logic        mem_valid,
   input  wire logic [15:0] mem_first,
   input  wire logic [15:0] mem_second,
   input  wire logic        mem_last,
   input  wire logic        mem_seg_end,
   output logic             mem_take,
   // Upstream chain
   input  wire logic        up_valid,
   input  wire logic [7:0]  up_data,
   input  wire logic        up_eob,
   input  wire logic        up_eof,
   output logic             up_ready,
   // Downstream chain
   output logic             dn_valid,
   output logic [7:0]       dn_data,
   output logic             dn_eob,
   output logic             dn_eof,
   input  wire logic        dn_ready
);
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] A_ROLE = 4'h0;
   localparam logic [3:0] A_SRC  = 4'h1;
   localparam logic [3:0] A_CTRL = 4'h2;
   localparam logic [3:0] A_STAT = 4'h3;
   localparam logic [3:0] A_ERR  = 4'h4;

   typedef enum {s_idle, s_fwd_pre, s_own, s_eof, s_fwd_post, s_pipe, s_pause} dcf_state_t;

   dcf_state_t  state, next_state;
   dcf_role_t   role;
   dcf_source_t source;
   logic [15:0] err;
   logic        run_memory;
   logic        mem_start_ok;
   logic        autostart;
   logic        seg_hold;
   logic        live_end;

   function automatic logic is_mem(input dcf_source_t s);
      is_mem = s == stored_first_channel_source || s == stored_second_channel_source
            || s == stored_both_source;
   endfunction
   function automatic logic is_framing(input dcf_role_t r);
      is_framing = r == role_a || r == role_orig || r == role_ins;
   endfunction

   wire wr_role  = wr && addr == A_ROLE && !meas_active;
   wire wr_src   = wr && addr == A_SRC  && !meas_active;
   wire wr_start = wr && addr == A_CTRL && wdata[0];
   wire wr_reset = wr && addr == A_CTRL && wdata[1];
   wire wr_clr   = wr && addr == A_ERR;
   assign mem_start_ok = wr_start && is_mem(source) && role != role_off && !meas_active;
   wire start_rej = wr_start && !mem_start_ok;
   wire dual      = source == stored_both_source || source == live_both_source;
   wire use_2     = source == stored_second_channel_source || source == live_second_channel_source;
   // Automatic memory transfer when role and source were valid before the run
   assign autostart = meas_done && is_framing(role) && is_mem(source);
   wire go = mem_start_ok || autostart;
   // Memory sources wait for the end of the run, so only live sources start on meas_active
   wire live_start = meas_active && is_framing(role) && !is_mem(source);
   // Off and pipe act on the chain at once, before the sequencer has caught up
   wire chain_on   = role != role_off;
   wire pipe_now   = role == role_pipe;
   wire framing_on = chain_on && !pipe_now;

   // ----------------------------------------
   // Own data path
   // ----------------------------------------
   dcf_chain_if own ();
   logic ser_busy;
   wire own_phase = framing_on && state == s_own;
   wire eof_phase = framing_on && state == s_eof;
   wire live_load = own_phase && !run_memory && conv_valid && !live_end;
   wire mem_load  = own_phase && run_memory && mem_valid && !seg_hold;
   assign mem_take = mem_load && !ser_busy;
   wire lost      = live_load && ser_busy;

   dcf_serializer u_ser (
      .clock       (clock),
      .nrst        (nrst),
      .load        (mem_take || (live_load && !ser_busy)),
      .dual        (dual),
      .use_second  (use_2),
      .first_word  (run_memory ? mem_first : conv_first),
      .second_word (run_memory ? mem_second : conv_second),
      .last        (run_memory && mem_last),
      .busy        (ser_busy),
      .out         (own)
   );

   dcf_seg_timer u_seg (
      .clock (clock),
      .nrst  (nrst),
      .start (mem_take && mem_seg_end),
      .hold  (seg_hold)
   );

   wire own_done = own.valid && own.eob && dn_ready;

   // ----------------------------------------
   // Chain routing
   // ----------------------------------------
   wire fwd = pipe_now || (framing_on && (state == s_fwd_pre || state == s_fwd_post));
   assign own.ready = own_phase && dn_ready;
   assign up_ready  = fwd && dn_ready;
   // Role_a swallows the upstream end-of-frame and re-emits its own later
   wire pre_eof_drop = framing_on && state == s_fwd_pre && up_eof;
   assign dn_valid = fwd ? up_valid && !pre_eof_drop
                   : own_phase ? own.valid : eof_phase;
   assign dn_data  = fwd ? up_data : own_phase ? own.data : 8'h00;
   assign dn_eob   = fwd ? up_eob : own_phase && own.eob;
   assign dn_eof   = fwd ? up_eof : eof_phase;
   wire up_xfer    = up_valid && up_ready;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         s_idle: begin
            if (role == role_pipe)
               next_state = s_pipe;
            else if (go || live_start)
               next_state = role == role_a ? s_fwd_pre : s_own;
         end
         s_fwd_pre:
            if (up_xfer && up_eof)
               next_state = s_own;
         s_own:
            if (own_done || (!run_memory && (meas_done || live_end) && !ser_busy))
               next_state = role == role_ins ? s_fwd_post : s_eof;
         s_eof:
            if (dn_ready)
               next_state = role == role_a ? s_pause : s_idle;
         s_fwd_post:
            if (up_xfer && up_eof)
               next_state = s_pause;
         s_pipe:
            next_state = s_pipe;
         s_pause:
            next_state = s_pause;
         default:
            next_state = s_idle;
      endcase
      if (role == role_off)
         next_state = s_idle;
      else if (role == role_pipe)
         next_state = s_pipe;
      else if (state == s_pipe)
         next_state = s_idle;
      if (wr_reset)
         next_state = s_idle;
   end

   always_ff @(posedge clock) begin
      if (!nrst)
         state <= s_idle;
      else
         state <= next_state;
   end

   always_ff @(posedge clock) begin
      if (!nrst)
         run_memory <= 1'b0;
      else if (state == s_idle && next_state != s_idle)
         run_memory <= go;
   end

   // A measurement end that meets a busy serializer is kept until the last byte is out
   always_ff @(posedge clock) begin
      if (!nrst)
         live_end <= 1'b0;
      else if (state != s_own)
         live_end <= 1'b0;
      else if (meas_done)
         live_end <= 1'b1;
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!nrst) begin
         role   <= dcf_role_t'(`DCF_RST_ROLE);
         source <= dcf_source_t'(`DCF_RST_SOURCE);
      end else begin
         if (wr_role)
            role <= dcf_role_t'(wdata[2:0]);
         if (wr_src)
            source <= dcf_source_t'(wdata[2:0]);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst)
         err <= 16'h0000;
      else if (lost)
         err <= `DCF_ERR_DATA_LOSS;
      else if (start_rej)
         err <= meas_active ? `DCF_ERR_BUSY : `DCF_ERR_BAD_START;
      else if (wr_clr)
         err <= 16'h0000;
   end

   wire [15:0] stat = {12'h000, state == s_pause, ser_busy, run_memory, state != s_idle};
   wire [15:0] rmux = addr == A_ROLE ? {13'h0, role}
                    : addr == A_SRC  ? {13'h0, source}
                    : addr == A_STAT ? stat
                    : addr == A_ERR  ? err : 16'h0000;
   always_ff @(posedge clock) begin
      if (!nrst)
         rdata <= 16'h0000;
      else
         rdata <= rd ? rmux : 16'h0000;
   end
endmodule
`default_nettype wire

// ### hdl/dcf_defines.svh
// Constants of the daisy chain data framer
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH
`define DCF_ERR_DATA_LOSS 16'h03FB
`define DCF_ERR_BAD_START 16'h0001
`define DCF_ERR_BUSY      16'h0002
`define DCF_RST_SOURCE    3'h2
`define DCF_RST_ROLE      3'h3
`define DCF_SEG_GAP       4'h4
`define DCF_RD_LATENCY    1
`endif

// ### hdl/dcf_pkg.sv
// Types of the daisy chain data framer
package dcf_pkg;
   typedef enum logic [2:0] {
      stored_first_channel_source  = 3'h0,
      stored_second_channel_source = 3'h1,
      stored_both_source           = 3'h2,
      live_first_channel_source    = 3'h3,
      live_second_channel_source   = 3'h4,
      live_both_source             = 3'h5
   } dcf_source_t;
   typedef enum logic [2:0] {
      role_a     = 3'h0,
      role_orig  = 3'h1,
      role_ins   = 3'h2,
      role_off   = 3'h3,
      role_pipe  = 3'h4
   } dcf_role_t;
endpackage

// ### hdl/dcf_chain_if.sv
// Chain byte stream carrier between framer modules
`timescale 1ns/1ps
`default_nettype none
interface dcf_chain_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   logic       eob;
   logic       eof;
   modport src (output valid, output data, output eob, output eof, input ready);
   modport snk (input valid, input data, input eob, input eof, output ready);
endinterface
`default_nettype wire

// ### hdl/dcf_serializer.sv
// Reading-to-byte serializer for own data
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"
module dcf_serializer
   import dcf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        load,
   input  wire logic        dual,
   input  wire logic        use_second,
   input  wire logic [15:0] first_word,
   input  wire logic [15:0] second_word,
   input  wire logic        last,
   output logic             busy,
   dcf_chain_if.src         out
);
   logic [31:0] shreg;
   logic [2:0]  left;
   logic        last_q;
   logic [31:0] next_shreg;
   logic [2:0]  next_left;

   // Dual sets go out channel 2 first; single words sit in the top half
   assign next_shreg = dual ? {second_word, first_word}
                     : {(use_second ? second_word : first_word), 16'h0000};
   assign next_left  = dual ? 3'd4 : 3'd2;
   assign busy       = left != 3'd0;
   assign out.valid  = busy;
   assign out.data   = shreg[31:24];
   assign out.eob    = last_q && left == 3'd1;
   assign out.eof    = 1'b0;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         shreg  <= 32'h0;
         left   <= 3'd0;
         last_q <= 1'b0;
      end else if (load && !busy) begin
         shreg  <= next_shreg;
         left   <= next_left;
         last_q <= last;
      end else if (busy && out.ready) begin
         shreg <= {shreg[23:0], 8'h00};
         left  <= left - 3'd1;
      end
   end
endmodule
`default_nettype wire

// ### hdl/dcf_seg_timer.sv
// Gap timer for segment address repointing
`timescale 1ns/1ps
`default_nettype none
`include "dcf_defines.svh"
module dcf_seg_timer (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic start,
   output logic      hold
);
   logic [3:0] cnt;
   assign hold = cnt != 4'd0;
   always_ff @(posedge clock) begin
      if (!nrst)
         cnt <= 4'd0;
      else if (start)
         cnt <= `DCF_SEG_GAP;
      else if (hold)
         cnt <= cnt - 4'd1;
   end
endmodule
`default_nettype wire

// ### sim/dcf_framer_monitor.sv
// Port-level assertions for the daisy chain framer
`timescale 1ns/1ps
`default_nettype none
module dcf_framer_monitor (
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [15:0] rdata,
   input wire logic        meas_active,
   input wire logic        meas_done,
   input wire logic        up_valid,
   input wire logic [7:0]  up_data,
   input wire logic        up_eob,
   input wire logic        up_eof,
   input wire logic        up_ready,
   input wire logic        dn_valid,
   input wire logic [7:0]  dn_data,
   input wire logic        dn_eob,
   input wire logic        dn_eof,
   input wire logic        dn_ready,
   input wire logic        mem_valid,
   input wire logic        mem_take
);
   // ----------------------------------------
   // Role shadow and checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   logic [2:0] role;
   // Writes during a measurement are refused, so the shadow skips them too
   always_ff @(posedge clock) begin
      if (!nrst)
         role <= 3'h3;
      else if (wr && addr == 4'h0 && !meas_active)
         role <= wdata[2:0];
   end
   off_quiet_a: assert property (role == 3'h3 |-> !up_ready && !dn_valid && !mem_take)
      else $error("chain active while disabled");
   pipe_data_a: assert property (role == 3'h4 |-> dn_valid == up_valid && dn_data == up_data)
      else $error("pass-through data altered");
   pipe_ready_a: assert property (role == 3'h4 |-> up_ready == dn_ready)
      else $error("pass-through ready not forwarded");
   pipe_flags_a: assert property (role == 3'h4 && up_valid |-> dn_eob == up_eob && dn_eof == up_eof)
      else $error("pass-through flags altered");
   hold_data_a: assert property (dn_valid && !dn_ready && !wr |=> dn_valid && $stable(dn_data))
      else $error("stalled byte dropped or changed");
   take_valid_a: assert property (mem_take |-> mem_valid ##1 !mem_take)
      else $error("memory taken without data");
   eof_beat_a: assert property (dn_valid && dn_eof && role != 3'h4 |-> dn_data == 8'h00)
      else $error("end-of-frame beat carries data");
   role_wait_a: assert property (wr && addr == 4'h0 && wdata[2:0] <= 3'h2 && !meas_active && !meas_done
      && !dn_valid && !mem_take |=> !dn_valid)
      else $error("framing role active before start");
   rd_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data outside read answer");
   cover property (role == 3'h4 && dn_valid && dn_ready);
   cover property (dn_valid && dn_eof && dn_ready);
   cover property (mem_take);
endmodule
bind dcf_framer dcf_framer_monitor i_mon (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .meas_active(meas_active), .meas_done(meas_done), .up_valid(up_valid),
   .up_data(up_data), .up_eob(up_eob), .up_eof(up_eof), .up_ready(up_ready), .dn_valid(dn_valid),
   .dn_data(dn_data), .dn_eob(dn_eob), .dn_eof(dn_eof), .dn_ready(dn_ready), .mem_valid(mem_valid),
   .mem_take(mem_take));
`default_nettype wire

// ### sim/dcf_sink_model.sv
// Downstream consumer model that records accepted beats
`timescale 1ns/1ps
`default_nettype none
module dcf_sink_model (
   input wire logic       clock,
   input wire logic       nrst,
   input wire logic       slow,
   input wire logic       hold,
   input wire logic       dn_valid,
   input wire logic [7:0] dn_data,
   input wire logic       dn_eof,
   output logic           dn_ready
);
   // ----------------------------------------
   // Consumer
   // ----------------------------------------
   logic [8:0] got[$];
   logic       phase;
   // Ready from reset on unless hold is set, every other cycle when slow, so no start runs into a dead chain end
   assign dn_ready = nrst && !hold && (!slow || phase);
   always @(posedge clock) begin
      phase <= nrst ? !phase : 1'b0;
      if (dn_valid && dn_ready)
         got.push_back({dn_eof, dn_data});
   end
endmodule
`default_nettype wire

// ### sim/dcf_framer_test.sv
// Self-checking testbench of the daisy chain framer
`timescale 1ns/1ps
`default_nettype none
module dcf_framer_test;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic        clock, nrst, wr, rd, meas_active, meas_done, conv_valid, mem_valid, mem_last, mem_seg_end;
   logic        up_valid, up_eob, up_eof, slow, hold, mem_take, up_ready, dn_valid, dn_eob, dn_eof, dn_ready;
   logic [3:0]  addr;
   logic [7:0]  up_data, dn_data;
   logic [15:0] wdata, rdata, conv_first, conv_second, mem_first, mem_second;
   logic [8:0]  e[$];
   int          err_count, tests_run, n, mem_offered, mem_taken;
   dcf_framer i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .meas_active(meas_active), .meas_done(meas_done), .conv_valid(conv_valid), .conv_first(conv_first),
      .conv_second(conv_second), .mem_valid(mem_valid), .mem_first(mem_first), .mem_second(mem_second),
      .mem_last(mem_last), .mem_seg_end(mem_seg_end), .mem_take(mem_take), .up_valid(up_valid),
      .up_data(up_data), .up_eob(up_eob), .up_eof(up_eof), .up_ready(up_ready), .dn_valid(dn_valid),
      .dn_data(dn_data), .dn_eob(dn_eob), .dn_eof(dn_eof), .dn_ready(dn_ready));
   dcf_sink_model i_sink (.clock(clock), .nrst(nrst), .slow(slow), .hold(hold), .dn_valid(dn_valid),
      .dn_data(dn_data), .dn_eof(dn_eof), .dn_ready(dn_ready));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Each offered stored set is consumed once; valid drops on its take
   assign mem_valid = mem_taken != mem_offered;
   always @(posedge clock) begin
      if (mem_take === 1'b1)
         mem_taken <= mem_taken + 1;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic up_send(input logic [7:0] d, input logic f);
      @(posedge clock);
      up_valid <= 1'b1;
      up_data <= d;
      up_eob <= f;
      up_eof <= f;
      n = 0;
      do @(posedge clock); while (up_ready !== 1'b1 && ++n < 50);
      up_valid <= 1'b0;
      up_data <= ~d;
   endtask
   task automatic wait_got(input int k);
      n = 0;
      while (i_sink.got.size() < k && n++ < 300)
         @(posedge clock);
      foreach (e[i])
         chk({7'h00, i_sink.got[i]}, {7'h00, e[i]});
      chk(16'(i_sink.got.size()), 16'(e.size()));
      wr_reg(4'h2, 16'h0002);
      i_sink.got.delete();
   endtask
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {nrst, wr, rd, meas_active, meas_done, conv_valid, up_valid, up_eob, up_eof, slow, hold} = '0;
      {addr, up_data, wdata, conv_first, conv_second} = '0;
      {mem_first, mem_second, mem_last, mem_seg_end} = {16'h1234, 16'hABCD, 1'b1, 1'b1};
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      rd_reg(4'h0, 16'h0003);
      rd_reg(4'h1, 16'h0002);
      up_valid <= 1'b1;
      repeat (3) @(posedge clock);
      chk({15'h0, up_ready}, 16'h0000);
      up_valid <= 1'b0;
      wr_reg(4'h0, 16'h0004);
      up_send(8'h5A, 1'b0);
      up_send(8'h00, 1'b1);
      up_send(8'hC3, 1'b0);
      e = {9'h05A, 9'h100, 9'h0C3};
      wait_got(3);
      $display("pass-through test done");
      wr_reg(4'h0, 16'h0003);
      wr_reg(4'h2, 16'h0001);
      rd_reg(4'h4, 16'h0001);
      wr_reg(4'h4, 16'h0000);
      wr_reg(4'h0, 16'h0001);
      wr_reg(4'h1, 16'h0003);
      wr_reg(4'h2, 16'h0001);
      rd_reg(4'h4, 16'h0001);
      wr_reg(4'h4, 16'h0000);
      rd_reg(4'h4, 16'h0000);
      chk(16'(i_sink.got.size()), 16'h0000);
      wr_reg(4'h1, 16'h0002);
      meas_active <= 1'b1;
      wr_reg(4'h0, 16'h0004);
      rd_reg(4'h0, 16'h0001);
      wr_reg(4'h2, 16'h0001);
      rd_reg(4'h4, 16'h0002);
      wr_reg(4'h4, 16'h0000);
      meas_active <= 1'b0;
      $display("start refusal test done");
      for (int s = 0; s < 3; s++) begin
         wr_reg(4'h1, 16'(s));
         mem_offered <= mem_offered + 1;
         slow <= s[0];
         wr_reg(4'h2, 16'h0001);
         e.delete();
         if (s != 0)
            e = {9'h0AB, 9'h0CD};
         if (s != 1)
            e = {e, 9'h012, 9'h034};
         e.push_back(9'h100);
         wait_got(e.size());
      end
      $display("memory run test done");
      wr_reg(4'h1, 16'h0003);
      hold <= 1'b1;
      meas_active <= 1'b1;
      conv_first <= 16'h5678;
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         conv_valid <= k[0] ? 1'b0 : 1'b1;
      end
      repeat (2) @(posedge clock);
      hold <= 1'b0;
      meas_done <= 1'b1;
      @(posedge clock);
      meas_done <= 1'b0;
      meas_active <= 1'b0;
      rd_reg(4'h4, 16'h03FB);
      e = {9'h056, 9'h078, 9'h100};
      wait_got(3);
      $display("data loss test done");
      wr_reg(4'h1, 16'h0000);
      wr_reg(4'h0, 16'h0000);
      mem_offered <= mem_offered + 1;
      wr_reg(4'h2, 16'h0001);
      up_send(8'h11, 1'b0);
      up_send(8'h00, 1'b1);
      repeat (8) @(posedge clock);
      rd_reg(4'h3, 16'h000B);
      e = {9'h011, 9'h012, 9'h034, 9'h100};
      wait_got(4);
      wr_reg(4'h0, 16'h0002);
      mem_offered <= mem_offered + 1;
      wr_reg(4'h2, 16'h0001);
      up_send(8'h22, 1'b0);
      up_send(8'h00, 1'b1);
      e = {9'h012, 9'h034, 9'h022, 9'h100};
      wait_got(4);
      $display("role_a and insert test done");
      finish_test;
   end
   // Whole sequence needs a few hundred cycles; allow 20000 cycles
   initial begin
      #400000;
      err_count++;
      finish_test;
   end
endmodule
`default_nettype wire
